// ==== design/priority_picker.v ====
`timescale 1ns/1ps
`default_nettype none

module priority_picker #(
    parameter N = 19,
    parameter W = 5
) (
    // Pending requests, index 0 is strongest
    input wire [N-1:0] req,
    // Result
    output wire any,
    output wire [W-1:0] idx
);

    wire [N:0] found;
    wire [W-1:0] pick [0:N];

    assign found[N] = 1'b0;
    assign pick[N] = {W{1'b0}};

    // Each stage defers to weaker stages only when idle, so lowest index wins
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_scan
            localparam [W-1:0] IDX = i;
            assign found[i] = found[i+1] | req[i];
            assign pick[i] = req[i] ? IDX : pick[i+1];
        end
    endgenerate

    assign any = found[0];
    assign idx = pick[0];

endmodule

`default_nettype wire

// ==== design/service_stack.v ====
`timescale 1ns/1ps
`default_nettype none

module service_stack #(
    parameter DEPTH = 8,
    parameter DW = 2,
    parameter CW = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Push on acknowledge, pop on return
    input wire push,
    input wire [DW-1:0] push_code,
    input wire pop,
    // Top of stack
    output wire busy,
    output wire [DW-1:0] top_code,
    output wire [CW-1:0] depth
);

    reg [DW-1:0] entry_ff [0:DEPTH-1];
    reg [CW-1:0] count_ff;
    wire full;

    localparam [CW-1:0] DEPTH_CW = DEPTH;

    assign full = (count_ff == DEPTH_CW);
    assign busy = (count_ff != {CW{1'b0}});
    assign top_code = entry_ff[0];
    assign depth = count_ff;

    // Entry 0 is the newest; deeper nesting than DEPTH drops the oldest
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    entry_ff[i] <= {DW{1'b0}};
                end else if (push) begin
                    if (i == 0) begin
                        entry_ff[i] <= push_code;
                    end else begin
                        entry_ff[i] <= entry_ff[i-1];
                    end
                end else if (pop) begin
                    if (i == DEPTH - 1) begin
                        entry_ff[i] <= {DW{1'b0}};
                    end else begin
                        entry_ff[i] <= entry_ff[i+1];
                    end
                end
            end
        end
    endgenerate

    // Occupancy count, saturating at both ends
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_ff <= {CW{1'b0}};
        end else if (push && !full) begin
            count_ff <= count_ff + {{(CW-1){1'b0}}, 1'b1};
        end else if (pop && !push && busy) begin
            count_ff <= count_ff - {{(CW-1){1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

// ==== design/vectored_interrupt_controller.v ====
// Overview of operation
// RULE1: Non-maskable request ignores global enable and priority, ranks above all.
// RULE2: A pending non-maskable request raises the standby release output.
// RULE3: In watchdog mode 1 the overflow is the non-maskable source, vector 0004H.
// RULE4: In interval mode the overflow is maskable slot 0, vector 0004H.
// RULE5: Maskable requests are gated by mask bits and split by level bits.
// RULE6: A high-level request may interrupt low-level service; highs may nest. The code blocks every maskable request during high-level service.
// RULE7: Within a level, the lowest default priority number wins, 0 to 18.
// RULE8: A pending unmasked maskable request also raises standby release.
// RULE9: Seven external and thirteen internal maskable request inputs exist.
// RULE10: External pin requests take slots 1 to 7, vectors 0006H to 0012H.
// RULE11: Serial 0 and 1 transfer ends take slots 8, 9, vectors 0014H, 0016H.
// RULE12: Serial 2 reception error takes slot 10, vector 0018H.
// RULE13: Serial 2 reception end and sync end share slot 11, vector 001AH.
// RULE14: Serial 2 transmission end takes slot 12, vector 001CH.
// RULE15: Watch timer interval is an internal maskable source in slot 13.
// RULE16: Timer16 compare matches take slots 14, 15, vectors 0020H, 0022H.
// RULE17: Timer8 counters 1 and 2 take slots 16, 17, vectors 0024H, 0026H.
// RULE18: Conversion end takes lowest slot 18, vector 0028H.
// RULE19: Break instruction raises vector 003EH, ignoring enable and priority.
// RULE20: Flags set on request or write, cleared on acknowledge; reset 0.
// RULE21: Mask bit 0 enables, 1 disables; reset sets all mask bits.
// RULE22: On acknowledge the selected vector table address goes to the core.
// RULE23: Maskable forwarded only with global enable and unblocked level.
`timescale 1ns/1ps
`default_nettype none
`include "vic_regs.vh"

module vectored_interrupt_controller #(
    parameter NSLOT = 19,
    parameter SW = 5,
    parameter STACK_DEPTH = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Avalon-MM register slave
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Internal request pulses
    input wire watchdog_overflow_req,
    input wire serial0_done_req,
    input wire serial1_done_req,
    input wire serial2_rx_error_req,
    input wire serial2_rx_done_req,
    input wire serial2_sync_done_req,
    input wire serial2_tx_done_req,
    input wire watch_interval_req,
    input wire timer16_match_a_req,
    input wire timer16_match_b_req,
    input wire timer8_a_match_req,
    input wire timer8_b_match_req,
    input wire conversion_done_req,
    // External pin edge request pulses
    input wire ext_pin_req_0,
    input wire ext_pin_req_1,
    input wire ext_pin_req_2,
    input wire ext_pin_req_3,
    input wire ext_pin_req_4,
    input wire ext_pin_req_5,
    input wire ext_pin_req_6,
    // Processor core side
    input wire break_instruction,
    input wire int_ack,
    input wire int_return,
    output wire int_req,
    output wire [15:0] int_vector,
    output wire standby_release
);

    ////////////////////////////////////////////////////////////////////////
    // State
    reg [NSLOT-1:0] flag_ff;
    reg [NSLOT-1:0] mask_ff;
    reg [NSLOT-1:0] level_ff;
    reg global_enable_flag_ff;
    reg wdt_mode1_ff;
    reg nmi_pend_ff;
    reg brk_pend_ff;
    reg int_req_ff;
    reg [15:0] int_vector_ff;
    reg [1:0] sel_kind_ff;
    reg [SW-1:0] sel_idx_ff;
    reg [1:0] sel_code_ff;
    reg standby_ff;
    reg bus_done_ff;
    reg [31:0] rdata_ff;

    reg [NSLOT-1:0] nxt_flag;
    reg [NSLOT-1:0] nxt_mask;
    reg [NSLOT-1:0] nxt_level;
    reg nxt_gen;
    reg nxt_wdm;
    reg nxt_nmi;
    reg nxt_brk;
    reg nxt_req;
    reg [15:0] nxt_vector;
    reg [1:0] nxt_kind;
    reg [SW-1:0] nxt_idx;
    reg [1:0] nxt_code;
    reg [31:0] nxt_rdata;

    wire [NSLOT-1:0] raw_req;
    wire [NSLOT-1:0] set_vec;
    wire [NSLOT-1:0] live;
    wire [NSLOT-1:0] hi_req;
    wire [NSLOT-1:0] lo_req;
    wire hi_any;
    wire lo_any;
    wire [SW-1:0] hi_idx;
    wire [SW-1:0] lo_idx;
    wire svc_busy;
    wire [1:0] svc_top;
    wire [3:0] svc_depth;
    wire block_hi;
    wire block_lo;
    wire take_ack;
    wire bus_req;
    wire bus_wr;
    wire [NSLOT-1:0] ack_clr;

    ////////////////////////////////////////////////////////////////////////
    // Request slot map
    // RULE9: twenty maskable inputs
    // RULE4: interval overflow in slot 0
    assign raw_req[0] = watchdog_overflow_req & ~wdt_mode1_ff;
    // RULE10: pins in slots 1 to 7
    assign raw_req[1] = ext_pin_req_0;
    assign raw_req[2] = ext_pin_req_1;
    assign raw_req[3] = ext_pin_req_2;
    assign raw_req[4] = ext_pin_req_3;
    assign raw_req[5] = ext_pin_req_4;
    assign raw_req[6] = ext_pin_req_5;
    assign raw_req[7] = ext_pin_req_6;
    // RULE11: serial 0 and 1
    assign raw_req[8] = serial0_done_req;
    assign raw_req[9] = serial1_done_req;
    // RULE12: reception error
    assign raw_req[10] = serial2_rx_error_req;
    // RULE13: two events share one flag
    assign raw_req[11] = serial2_rx_done_req | serial2_sync_done_req;
    // RULE14: transmission end
    assign raw_req[12] = serial2_tx_done_req;
    // RULE15: watch timer interval
    assign raw_req[13] = watch_interval_req;
    // RULE16: timer16 compare matches
    assign raw_req[14] = timer16_match_a_req;
    assign raw_req[15] = timer16_match_b_req;
    // RULE17: timer8 matches
    assign raw_req[16] = timer8_a_match_req;
    assign raw_req[17] = timer8_b_match_req;
    // RULE18: conversion end, weakest
    assign raw_req[18] = conversion_done_req;

    ////////////////////////////////////////////////////////////////////////
    // Arbitration
    // RULE5: mask gating and level split
    assign live = flag_ff & ~mask_ff;
    assign hi_req = live & ~level_ff;
    assign lo_req = live & level_ff;

    // RULE6: high service blocks all, low service blocks only lows
    assign block_hi = svc_busy && (svc_top == `VIC_SVC_HIGH);
    assign block_lo = block_hi || (svc_busy && (svc_top == `VIC_SVC_LOW));

    // RULE7: fixed order within each level
    priority_picker #(
        .N(NSLOT),
        .W(SW)
    ) u_pick_hi (
        .req(hi_req),
        .any(hi_any),
        .idx(hi_idx)
    );

    priority_picker #(
        .N(NSLOT),
        .W(SW)
    ) u_pick_lo (
        .req(lo_req),
        .any(lo_any),
        .idx(lo_idx)
    );

    // The core only acknowledges what is shown; a stray ack is ignored
    assign take_ack = int_ack & int_req_ff;

    // RULE20: acknowledge clears only the slot that was shown
    genvar g;
    generate
        for (g = 0; g < NSLOT; g = g + 1) begin : g_clr
            localparam [SW-1:0] SLOT = g;
            assign ack_clr[g] = take_ack && (sel_kind_ff == `VIC_SEL_MASK) &&
                                (sel_idx_ff == SLOT);
        end
    endgenerate

    // Nesting record of services in progress
    service_stack #(
        .DEPTH(STACK_DEPTH),
        .DW(2),
        .CW(4)
    ) u_stack (
        .clk(clk),
        .rst(rst),
        .push(take_ack),
        .push_code(sel_code_ff),
        .pop(int_return),
        .busy(svc_busy),
        .top_code(svc_top),
        .depth(svc_depth)
    );

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM: one wait state on every access
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~bus_done_ff;
    assign bus_wr = avs_write & bus_done_ff;
    assign avs_readdata = rdata_ff;

    // Read data is captured during the wait state and held to completion
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (avs_address)
            `VIC_OFS_FLAG: begin
                nxt_rdata[NSLOT-1:0] = flag_ff;
            end
            `VIC_OFS_MASK: begin
                nxt_rdata[NSLOT-1:0] = mask_ff;
            end
            `VIC_OFS_LEVEL: begin
                nxt_rdata[NSLOT-1:0] = level_ff;
            end
            `VIC_OFS_CTRL: begin
                nxt_rdata[`VIC_CTRL_GEN_BIT] = global_enable_flag_ff;
                nxt_rdata[`VIC_CTRL_WDM_BIT] = wdt_mode1_ff;
            end
            `VIC_OFS_STAT: begin
                nxt_rdata[`VIC_STAT_VEC_LSB+15:`VIC_STAT_VEC_LSB] =
                    int_vector_ff;
                nxt_rdata[`VIC_STAT_REQ_BIT] = int_req_ff;
                nxt_rdata[`VIC_STAT_NMI_BIT] = nmi_pend_ff;
                nxt_rdata[`VIC_STAT_BRK_BIT] = brk_pend_ff;
                nxt_rdata[`VIC_STAT_BUSY_BIT] = svc_busy;
                nxt_rdata[`VIC_STAT_TOP_LSB+1:`VIC_STAT_TOP_LSB] = svc_top;
                nxt_rdata[`VIC_STAT_TOP_LSB+5:`VIC_STAT_TOP_LSB+2] =
                    svc_depth;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Software writes, hardware sets and acknowledge clears
    always @* begin
        nxt_flag = flag_ff;
        nxt_mask = mask_ff;
        nxt_level = level_ff;
        nxt_gen = global_enable_flag_ff;
        nxt_wdm = wdt_mode1_ff;
        nxt_nmi = nmi_pend_ff;
        nxt_brk = brk_pend_ff;
        if (bus_wr) begin
            case (avs_address)
                `VIC_OFS_FLAG: begin
                    nxt_flag = avs_writedata[NSLOT-1:0];
                end
                // RULE21: mask bit 1 disables
                `VIC_OFS_MASK: begin
                    nxt_mask = avs_writedata[NSLOT-1:0];
                end
                `VIC_OFS_LEVEL: begin
                    nxt_level = avs_writedata[NSLOT-1:0];
                end
                `VIC_OFS_CTRL: begin
                    nxt_gen = avs_writedata[`VIC_CTRL_GEN_BIT];
                    nxt_wdm = avs_writedata[`VIC_CTRL_WDM_BIT];
                end
                default: begin
                    nxt_gen = global_enable_flag_ff;
                end
            endcase
        end
        // RULE20: set wins over a clear in the same cycle
        nxt_flag = (nxt_flag & ~ack_clr) | raw_req;
        // Slot 0 cannot hold a request while the watchdog is the NMI
        if (wdt_mode1_ff) begin
            nxt_flag[0] = 1'b0;
        end
        // Servicing any request shuts the gate until software reopens it
        if (take_ack) begin
            nxt_gen = 1'b0;
        end
        // RULE3: overflow in watchdog mode 1 is the non-maskable source
        if (take_ack && (sel_kind_ff == `VIC_SEL_NMI)) begin
            nxt_nmi = 1'b0;
        end
        nxt_nmi = nxt_nmi | (watchdog_overflow_req & wdt_mode1_ff);
        // RULE19: break is latched until the core takes it
        if (take_ack && (sel_kind_ff == `VIC_SEL_BRK)) begin
            nxt_brk = 1'b0;
        end
        nxt_brk = nxt_brk | break_instruction;
    end

    ////////////////////////////////////////////////////////////////////////
    // Selection of the request shown to the core
    always @* begin
        nxt_req = 1'b0;
        nxt_vector = int_vector_ff;
        nxt_kind = `VIC_SEL_NONE;
        nxt_idx = {SW{1'b0}};
        nxt_code = `VIC_SVC_EXEMPT;
        if (int_req_ff && !take_ack) begin
            // Hold the shown request stable until it is taken
            nxt_req = 1'b1;
            nxt_kind = sel_kind_ff;
            nxt_idx = sel_idx_ff;
            nxt_code = sel_code_ff;
        end else if (take_ack) begin
            // One idle cycle lets the cleared flag settle before re-arbitrating
            nxt_req = 1'b0;
        // RULE1: non-maskable ignores enable and nesting, ranks first
        end else if (nmi_pend_ff) begin
            nxt_req = 1'b1;
            nxt_vector = `VIC_VEC_NMI;
            nxt_kind = `VIC_SEL_NMI;
        // RULE19: break ignores enable and nesting
        end else if (brk_pend_ff) begin
            nxt_req = 1'b1;
            nxt_vector = `VIC_VEC_BRK;
            nxt_kind = `VIC_SEL_BRK;
        // RULE23: global enable and level blocking gate maskables
        end else if (global_enable_flag_ff && hi_any && !block_hi) begin
            nxt_req = 1'b1;
            nxt_vector = `VIC_VEC_BASE + {{(15-SW){1'b0}}, hi_idx, 1'b0};
            nxt_kind = `VIC_SEL_MASK;
            nxt_idx = hi_idx;
            nxt_code = `VIC_SVC_HIGH;
        end else if (global_enable_flag_ff && lo_any && !block_lo) begin
            nxt_req = 1'b1;
            nxt_vector = `VIC_VEC_BASE + {{(15-SW){1'b0}}, lo_idx, 1'b0};
            nxt_kind = `VIC_SEL_MASK;
            nxt_idx = lo_idx;
            nxt_code = `VIC_SVC_LOW;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register update
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            // RULE20: flags reset clear
            flag_ff <= `VIC_FLAG_RST;
            // RULE21: all masked at reset
            mask_ff <= `VIC_MASK_RST;
            level_ff <= `VIC_LEVEL_RST;
            global_enable_flag_ff <= 1'b0;
            wdt_mode1_ff <= 1'b0;
            nmi_pend_ff <= 1'b0;
            brk_pend_ff <= 1'b0;
            int_req_ff <= 1'b0;
            int_vector_ff <= 16'h0000;
            sel_kind_ff <= `VIC_SEL_NONE;
            sel_idx_ff <= {SW{1'b0}};
            sel_code_ff <= `VIC_SVC_EXEMPT;
            standby_ff <= 1'b0;
            bus_done_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            flag_ff <= nxt_flag;
            mask_ff <= nxt_mask;
            level_ff <= nxt_level;
            global_enable_flag_ff <= nxt_gen;
            wdt_mode1_ff <= nxt_wdm;
            nmi_pend_ff <= nxt_nmi;
            brk_pend_ff <= nxt_brk;
            // RULE22: vector held with the request
            int_req_ff <= nxt_req;
            int_vector_ff <= nxt_vector;
            sel_kind_ff <= nxt_kind;
            sel_idx_ff <= nxt_idx;
            sel_code_ff <= nxt_code;
            // RULE2: NMI wakes from standby
            // RULE8: unmasked flag wakes regardless of enable
            standby_ff <= nmi_pend_ff | (|live);
            bus_done_ff <= bus_req & ~bus_done_ff;
            if (bus_req && !bus_done_ff) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign int_req = int_req_ff;
    assign int_vector = int_vector_ff;
    assign standby_release = standby_ff;

endmodule

`default_nettype wire

// ==== design/vic_regs.vh ====
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// Register byte offsets on the Avalon-MM slave
`define VIC_OFS_FLAG 5'h00
`define VIC_OFS_MASK 5'h04
`define VIC_OFS_LEVEL 5'h08
`define VIC_OFS_CTRL 5'h0C
`define VIC_OFS_STAT 5'h10

// Reset values
`define VIC_FLAG_RST 19'h0_0000
`define VIC_MASK_RST 19'h7_FFFF
`define VIC_LEVEL_RST 19'h7_FFFF
`define VIC_CTRL_RST 2'h0

// Control register fields
`define VIC_CTRL_GEN_BIT 0
`define VIC_CTRL_WDM_BIT 1

// Status register fields
`define VIC_STAT_VEC_LSB 0
`define VIC_STAT_REQ_BIT 16
`define VIC_STAT_NMI_BIT 17
`define VIC_STAT_BRK_BIT 18
`define VIC_STAT_BUSY_BIT 19
`define VIC_STAT_TOP_LSB 20

// Vector table addresses
`define VIC_VEC_NMI 16'h0004
`define VIC_VEC_BASE 16'h0004
`define VIC_VEC_BRK 16'h003E

// Service stack entry codes
`define VIC_SVC_HIGH 2'h0
`define VIC_SVC_LOW 2'h1
`define VIC_SVC_EXEMPT 2'h2

// Kinds of the request presented to the core
`define VIC_SEL_NONE 2'h0
`define VIC_SEL_NMI 2'h1
`define VIC_SEL_BRK 2'h2
`define VIC_SEL_MASK 2'h3

`endif

// ==== tb/core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request from the controller, and the acknowledge delay from the bench
    input wire logic int_req,
    input wire logic [15:0] int_vector,
    input wire logic [1:0] ack_delay,
    // Acknowledge and fetched vector
    output logic int_ack,
    output logic [15:0] got_vector,
    output logic [7:0] n_acks
);
    logic [1:0] wait_ff;
    ///////////////////////////////
    // fetch on acknowledge
    // Slow cores check that the request holds
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            int_ack <= 1'h0;
            wait_ff <= 2'h0;
            got_vector <= 16'h0000;
            n_acks <= 8'h00;
        end else begin
            int_ack <= 1'h0;
            if (int_req && !int_ack) begin
                if (wait_ff >= ack_delay) begin
                    int_ack <= 1'h1;
                    got_vector <= int_vector;
                    n_acks <= n_acks + 8'h01;
                    wait_ff <= 2'h0;
                end else begin
                    wait_ff <= wait_ff + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/vectored_interrupt_controller_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vic_regs.vh"
module vectored_interrupt_controller_bench;
    logic clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic break_instruction = 0, int_return = 0;
    logic [4:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, rd;
    logic [19:0] src = 0;
    logic [1:0] ack_delay = 0;
    logic [18:0] m_flag = 0, m_mask, m_level;
    logic [31:0] rst_tab [6] = '{0, 32'h0007_ffff, 32'h0007_ffff, 0, 0, 0};
    wire [31:0] avs_readdata;
    wire [15:0] int_vector, got_vector;
    wire [7:0] n_acks;
    wire avs_waitrequest, int_req, int_ack, standby_release;
    int n_mismatch = 0, n_checks = 0, cyc = 0, r;
    integer seed = 32'h638f_4cea;
    int svc[$];
    ///////////////////////////////
    always #2.5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out;
        end
    end
    vectored_interrupt_controller u_vectored_interrupt_controller (
        .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest,
        .watchdog_overflow_req(src[0]), .ext_pin_req_0(src[1]),
        .ext_pin_req_1(src[2]), .ext_pin_req_2(src[3]),
        .ext_pin_req_3(src[4]), .ext_pin_req_4(src[5]),
        .ext_pin_req_5(src[6]), .ext_pin_req_6(src[7]),
        .serial0_done_req(src[8]), .serial1_done_req(src[9]),
        .serial2_rx_error_req(src[10]), .serial2_rx_done_req(src[11]),
        .serial2_tx_done_req(src[12]), .watch_interval_req(src[13]),
        .timer16_match_a_req(src[14]), .timer16_match_b_req(src[15]),
        .timer8_a_match_req(src[16]), .timer8_b_match_req(src[17]),
        .conversion_done_req(src[18]), .serial2_sync_done_req(src[19]),
        .break_instruction, .int_ack, .int_return, .int_req, .int_vector,
        .standby_release);
    core_model u_core_model (.clk, .rst, .int_req, .int_vector, .ack_delay,
        .int_ack, .got_vector, .n_acks);
    ///////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Held until waitrequest is low at an edge
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(posedge clk);
    endtask
    task pulse(input logic [19:0] m, input logic b);
        src <= m;
        m_flag = m_flag | m[18:0] | {m[19], 11'h000};
        break_instruction <= b;
        @(posedge clk);
        src <= 0;
        break_instruction <= 0;
        @(posedge clk);
    endtask
    // Await an ack, update the model
    task serve(input logic [15:0] v, input logic exempt);
        logic [7:0] n0;
        n0 = n_acks;
        ack_delay <= 2'($random(seed));
        while (n_acks === n0) @(posedge clk);
        chk(32'(got_vector), 32'(v));
        if (exempt) svc.push_back(2);
        else begin
            svc.push_back(int'(m_level[(v - 4) / 2]));
            m_flag[(v - 4) / 2] = 0;
        end
        repeat (2) @(posedge clk);
    endtask
    task ret;
        int_return <= 1;
        @(posedge clk);
        int_return <= 0;
        void'(svc.pop_back());
        @(posedge clk);
    endtask
    task quiet;
        logic [7:0] n0;
        n0 = n_acks;
        repeat (8) @(posedge clk);
        chk(32'(n_acks), 32'(n0));
    endtask
    // Stack top 0 blocks all, 1 blocks lows
    function automatic logic [15:0] pick();
        int top;
        top = svc.size() ? svc[$] : 2;
        for (int g = 0; g < 2; g++)
            for (int i = 0; i < 19; i++)
                if (m_flag[i] && !m_mask[i] && m_level[i] == g && g < top)
                    return 16'(4 + 2 * i);
        return 16'h0000;
    endfunction
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ///////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            bus(0, 5'(4 * i), 0);
            chk(rd, rst_tab[i]);
        end
        // Each slot vs a random rival
        bus(1, `VIC_OFS_MASK, 0);
        bus(1, `VIC_OFS_LEVEL, 0);
        m_mask = 0;
        m_level = 0;
        for (int s = 0; s < 19; s++) begin
            r = ($random(seed) & 32'h7fff) % 19;
            bus(1, `VIC_OFS_CTRL, 1);
            pulse((s == 11 ? 20'h8_0000 : 20'(1 << s)) | 20'(1 << r), 0);
            serve(pick(), 0);
            ret;
            if (m_flag) begin
                bus(1, `VIC_OFS_CTRL, 1);
                serve(pick(), 0);
                ret;
            end
        end
        // Masked or disabled stay silent
        bus(1, `VIC_OFS_MASK, 32'h0007_fffb);
        m_mask = 19'h7_fffb;
        pulse(20'h0_0020, 0);
        quiet;
        chk(32'(standby_release), 0);
        bus(0, `VIC_OFS_FLAG, 0);
        chk(rd, 32'h0000_0020);
        pulse(20'h0_0004, 0);
        quiet;
        chk(32'(standby_release), 1);
        bus(1, `VIC_OFS_CTRL, 1);
        serve(pick(), 0);
        ret;
        bus(1, `VIC_OFS_FLAG, 32'h0000_0200);
        m_flag = 19'h0_0200;
        bus(1, `VIC_OFS_MASK, 0);
        m_mask = 0;
        bus(1, `VIC_OFS_CTRL, 1);
        serve(pick(), 0);
        ret;
        // Highs nest over lows
        bus(1, `VIC_OFS_LEVEL, 32'h0006_0000);
        m_level = 19'h6_0000;
        bus(1, `VIC_OFS_CTRL, 1);
        pulse(20'h4_0000, 0);
        serve(pick(), 0);
        bus(1, `VIC_OFS_CTRL, 1);
        pulse(20'h2_0000, 0);
        quiet;
        pulse(20'h0_0020, 0);
        serve(pick(), 0);
        bus(1, `VIC_OFS_CTRL, 1);
        pulse(20'h0_0008, 0);
        quiet;
        ret;
        serve(pick(), 0);
        ret;
        ret;
        bus(1, `VIC_OFS_CTRL, 1);
        serve(pick(), 0);
        ret;
        // NMI and break with enable off
        bus(1, `VIC_OFS_CTRL, 32'h0000_0002);
        pulse(20'h0_0001, 1);
        @(negedge clk);
        chk(32'(standby_release), 1);
        @(posedge clk);
        serve(16'h0004, 1);
        serve(16'h003E, 1);
        ret;
        ret;
        close_out;
    end
endmodule
bind vectored_interrupt_controller vic_properties u_vic_properties (
    .clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
    .break_instruction, .int_ack, .int_req, .int_vector, .standby_release);
`default_nettype wire

// ==== tb/vic_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module vic_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Core side
    input wire logic break_instruction,
    input wire logic int_ack,
    input wire logic int_req,
    input wire logic [15:0] int_vector,
    input wire logic standby_release
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ///////////////////////////////
    // One wait state per access
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait state is not one cycle");
    a_wait_rearm: assert property ((avs_read || avs_write) && !avs_waitrequest
        |=> avs_waitrequest || !(avs_read || avs_write))
        else $error("second access skipped its wait state");
    a_idle_ready: assert property (!(avs_read || avs_write)
        |-> !avs_waitrequest) else $error("stall raised with no access");
    // Request holds until taken
    a_req_stands: assert property (int_req && !int_ack
        |=> int_req && $stable(int_vector)) else $error("request moved");
    a_ack_drops: assert property (int_req && int_ack |=> !int_req)
        else $error("request held after acknowledge");
    // Only table entries
    a_vec_legal: assert property (int_req |-> !int_vector[0] &&
        (int_vector inside {[16'h0004:16'h0028], 16'h003E}))
        else $error("vector outside the table");
    // A latched break is shown soon
    a_brk_shows: assert property (break_instruction && !int_req
        |-> ##[1:3] int_req) else $error("break raised no request");
    // Shown maskables and NMI wake
    a_rose_wakes: assert property ($rose(int_req) &&
        int_vector != 16'h003E |-> standby_release)
        else $error("request without standby release");
endmodule
`default_nettype wire
